// [event_source_model.sv]
// Model of the peripheral event sources beside the bank.
// Assumes the caller invokes its tasks from the bench's clock domain.
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
    input wire logic mclk_in,
    output var sfr_bank_pkg::event_s events_out
);
    logic [8:0] level_reg = 9'h000;
    initial events_out = '0;
    // ==========
    // One-cycle pulse laid over the held levels
    task automatic pulse(input logic [8:0] p);
        @(posedge mclk_in);
        events_out <= sfr_bank_pkg::event_s'(p | level_reg);
        @(posedge mclk_in);
        events_out <= sfr_bank_pkg::event_s'(level_reg);
    endtask
    // Level inputs: mode, fault and violation
    task automatic hold(input logic [8:0] l);
        @(posedge mclk_in);
        level_reg = l;
        events_out <= sfr_bank_pkg::event_s'(l);
    endtask
endmodule
`default_nettype wire

// [sfr_bank_consts.svh]
// Constants of the special function register bank: offsets, bit places,
// reset values. Assumes inclusion by bare name; definitions only.
`ifndef SFR_BANK_CONSTS_SVH
`define SFR_BANK_CONSTS_SVH

// ==========================================================
// Bus widths and decode of the special function space
`define SFR_ADDR_W 16
`define SFR_DATA_W 8
`define SFR_OFS_W 4
`define SFR_HI_ZERO 12'h000
`define SFR_BYTE_ZERO 8'h00

// ==========================================================
// Register offsets inside the special function space
`define OFS_IRQ_EN_1 4'h0
`define OFS_IRQ_EN_2 4'h1
`define OFS_IRQ_FLAGS_1 4'h2
`define OFS_IRQ_FLAGS_2 4'h3
`define OFS_MODULE_ON_1 4'h4
`define OFS_MODULE_ON_2 4'h5

// ==========================================================
// Bit places
`define BIT_WDOG 0
`define BIT_OSC_FAULT 1
`define BIT_PIN_NMI 4
`define BIT_FLASH_VIOL 5
`define BIT_SERIAL_RX 0
`define BIT_SERIAL_TX 1
`define BIT_SERIAL_SPI 2
`define SERIAL_CHANNELS 2

// ==========================================================
// Values forced by power-on reset and by power_up_clear
`define VAL_CLEAR 1'b0
`define VAL_OSC_FAULT_PUC 1'b1
`define VAL_SERIAL_PUC 2'h0

`endif

// [sfr_bank_pkg.sv]
// Types of the special function register bank.
// Assumes the constants header is on the include path.
`include "sfr_bank_consts.svh"

package sfr_bank_pkg;

    typedef logic [`SFR_DATA_W-1:0] byte_t;

    // ==========================================================
    // Peripheral bus request, synchronous to the system clock
    typedef struct packed {
        logic [`SFR_ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [`SFR_DATA_W-1:0] wdata;
    } bus_req_s;

    // ==========================================================
    // Events from the watchdog, clock system, pin logic, flash, serial
    typedef struct packed {
        logic wdog_overflow;
        logic key_violation;
        logic pin_reset;
        logic wdog_interval_mode;
        logic osc_fault;
        logic pin_nmi_event;
        logic flash_viol_flag;
        logic serial_rx_event;
        logic serial_tx_event;
    } event_s;

    // ==========================================================
    // Interrupt requests and module enables
    typedef struct packed {
        logic wdog_irq;
        logic sys_nmi_irq;
        logic serial_rx_irq;
        logic serial_tx_irq;
    } irq_s;

    typedef struct packed {
        logic serial_uart_rx_on;
        logic serial_uart_tx_on;
        logic serial_spi_on;
    } module_on_s;

endpackage

// [sfr_bank_props.sv]
// Checker of the special function register bank, port relations only.
// Assumes it is bound to the bank and sees its ports alone.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_props (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic power_up_clear_in,
    input wire sfr_bank_pkg::bus_req_s bus_req_in,
    input wire sfr_bank_pkg::event_s events_in,
    input wire sfr_bank_pkg::byte_t bus_rdata_out,
    input wire logic bus_rvalid_out,
    input wire sfr_bank_pkg::irq_s irq_out,
    input wire sfr_bank_pkg::module_on_s module_on_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic hit;
    logic wr_hit;
    logic [3:0] ofs;
    assign hit = bus_req_in.rd && (bus_req_in.addr[15:4] == 12'h000);
    assign wr_hit = bus_req_in.wr && (bus_req_in.addr == 16'h0005);
    assign ofs = bus_req_in.addr[3:0];
    // ==========
    // Bus answers and module enable writes
    property p_answer;
        hit |=> bus_rvalid_out;
    endproperty
    a_answer: assert property (p_answer)
        else $error("read got no answer");
    property p_no_answer;
        !hit |=> !bus_rvalid_out && bus_rdata_out == 8'h00;
    endproperty
    a_no_answer: assert property (p_no_answer)
        else $error("answer without bank read");
    property p_flags2_width;
        hit && ofs == 4'h3 |=> bus_rdata_out[7:2] == 6'h00;
    endproperty
    a_flags2_width: assert property (p_flags2_width)
        else $error("flags two upper bits set");
    property p_absent_zero;
        hit && (ofs == 4'h4 || ofs > 4'h5) |=> bus_rdata_out == 8'h00;
    endproperty
    a_absent_zero: assert property (p_absent_zero)
        else $error("absent byte read nonzero");
    property p_module_on;
        wr_hit && !power_up_clear_in |=> module_on_out == {$past(bus_req_in.wdata[0]),
            $past(bus_req_in.wdata[1]), $past(bus_req_in.wdata[2])};
    endproperty
    a_module_on: assert property (p_module_on)
        else $error("module enables differ from write");
    // ==========
    // Interrupt outputs
    property p_wdog_mode;
        !events_in.wdog_interval_mode |=> !irq_out.wdog_irq;
    endproperty
    a_wdog_mode: assert property (p_wdog_mode)
        else $error("watchdog irq outside interval mode");
    property p_pin_reset;
        events_in.pin_reset && !events_in.wdog_overflow && !events_in.key_violation
            |=> ##1 !irq_out.wdog_irq;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("watchdog flag survived pin reset");
    property p_puc;
        power_up_clear_in |=> module_on_out == 3'b000 ##1
            (!irq_out.serial_rx_irq && !irq_out.serial_tx_irq && !irq_out.sys_nmi_irq);
    endproperty
    a_puc: assert property (p_puc)
        else $error("clear left enables set");
endmodule
`default_nettype wire

// [special_function_reg_bank.sv]
// Special function register bank: interrupt enables, interrupt flags and
// module enables in the lowest bytes of the peripheral space.
// Assumes bus and event inputs synchronous to mclk_in, arst_n_in as
// power-on reset, and power_up_clear_in as a one-cycle synchronous pulse.
//
// Functional notes
// [RQ1] Flip-flops only for bits with a function
// [RQ2] Bank decoded at the lowest sixteen addresses
// [RQ3] Watchdog enable gates interval-mode interrupt only
// [RQ4] Watchdog flag set by overflow or bad key
// [RQ5] Watchdog flag cleared by power-on, pin reset
// [RQ6] Oscillator fault report sets oscillator flag
// [RQ7] NMI pin event sets NMI flag
// [RQ8] Own enables for oscillator, NMI, flash violation
// [RQ9] Serial receive and transmit enables, any mode
// [RQ10] Flags register two: transmit bit 1, receive 0
// [RQ11] Clear bits by power_up_clear, others by power-on
// [RQ12] UART receive, UART transmit, SPI module enables
// [RQ13] Nonmaskable events gated by own enable only
// [RQ14] Absent bits read zero, ignore writes
// [RQ15] Hardware set beats software clear
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_consts.svh"

module special_function_reg_bank (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic power_up_clear_in,
    input wire sfr_bank_pkg::bus_req_s bus_req_in,
    input wire sfr_bank_pkg::event_s events_in,
    output var sfr_bank_pkg::byte_t bus_rdata_out,
    output logic bus_rvalid_out,
    output var sfr_bank_pkg::irq_s irq_out,
    output var sfr_bank_pkg::module_on_s module_on_out
);

    // Software write wins over held value, hardware set wins over both
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic wr, input logic wbit);
        logic v;
        v = cur;
        if (wr) begin
            v = wbit;
        end
        if (set) begin
            v = 1'b1; // RQ15
        end
        return v;
    endfunction

    // ==========================================================
    // Address decode
    logic sfr_hit;
    logic [`SFR_OFS_W-1:0] ofs;
    logic wr_en_1;
    logic wr_en_2;
    logic wr_flags_1;
    logic wr_flags_2;
    logic wr_on_2;
    sfr_bank_pkg::byte_t wdata;

    always_comb begin
        sfr_hit = (bus_req_in.addr[`SFR_ADDR_W-1:`SFR_OFS_W] == `SFR_HI_ZERO); // RQ2
        ofs = bus_req_in.addr[`SFR_OFS_W-1:0];
        wdata = bus_req_in.wdata;
        wr_en_1 = sfr_hit && bus_req_in.wr && (ofs == `OFS_IRQ_EN_1);
        wr_en_2 = sfr_hit && bus_req_in.wr && (ofs == `OFS_IRQ_EN_2);
        wr_flags_1 = sfr_hit && bus_req_in.wr && (ofs == `OFS_IRQ_FLAGS_1);
        wr_flags_2 = sfr_hit && bus_req_in.wr && (ofs == `OFS_IRQ_FLAGS_2);
        wr_on_2 = sfr_hit && bus_req_in.wr && (ofs == `OFS_MODULE_ON_2);
    end

    // ==========================================================
    // Interrupt enables
    logic wdog_irq_en_reg;
    logic wdog_irq_en_next;
    logic osc_fault_irq_en_reg;
    logic osc_fault_irq_en_next;
    logic pin_nmi_irq_en_reg;
    logic pin_nmi_irq_en_next;
    logic flash_viol_irq_en_reg;
    logic flash_viol_irq_en_next;
    logic serial_rx_irq_en_reg;
    logic serial_rx_irq_en_next;
    logic serial_tx_irq_en_reg;
    logic serial_tx_irq_en_next;

    always_comb begin
        wdog_irq_en_next = wdog_irq_en_reg;
        osc_fault_irq_en_next = osc_fault_irq_en_reg;
        pin_nmi_irq_en_next = pin_nmi_irq_en_reg;
        flash_viol_irq_en_next = flash_viol_irq_en_reg;
        serial_rx_irq_en_next = serial_rx_irq_en_reg;
        serial_tx_irq_en_next = serial_tx_irq_en_reg;
        if (wr_en_1) begin
            wdog_irq_en_next = wdata[`BIT_WDOG];
            osc_fault_irq_en_next = wdata[`BIT_OSC_FAULT]; // RQ8
            pin_nmi_irq_en_next = wdata[`BIT_PIN_NMI]; // RQ8
            flash_viol_irq_en_next = wdata[`BIT_FLASH_VIOL]; // RQ8
        end
        if (wr_en_2) begin
            serial_rx_irq_en_next = wdata[`BIT_SERIAL_RX]; // RQ9
            serial_tx_irq_en_next = wdata[`BIT_SERIAL_TX]; // RQ9
        end
        if (power_up_clear_in) begin
            wdog_irq_en_next = `VAL_CLEAR; // RQ11
            osc_fault_irq_en_next = `VAL_CLEAR;
            pin_nmi_irq_en_next = `VAL_CLEAR;
            flash_viol_irq_en_next = `VAL_CLEAR;
            serial_rx_irq_en_next = `VAL_CLEAR;
            serial_tx_irq_en_next = `VAL_CLEAR;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_irq_en_reg <= `VAL_CLEAR;
            osc_fault_irq_en_reg <= `VAL_CLEAR;
            pin_nmi_irq_en_reg <= `VAL_CLEAR;
            flash_viol_irq_en_reg <= `VAL_CLEAR;
            serial_rx_irq_en_reg <= `VAL_CLEAR;
            serial_tx_irq_en_reg <= `VAL_CLEAR;
        end else begin
            wdog_irq_en_reg <= wdog_irq_en_next;
            osc_fault_irq_en_reg <= osc_fault_irq_en_next;
            pin_nmi_irq_en_reg <= pin_nmi_irq_en_next;
            flash_viol_irq_en_reg <= flash_viol_irq_en_next;
            serial_rx_irq_en_reg <= serial_rx_irq_en_next;
            serial_tx_irq_en_reg <= serial_tx_irq_en_next;
        end
    end

    // ==========================================================
    // System flags
    logic wdog_event_flag_reg;
    logic wdog_event_flag_next;
    logic osc_fault_flag_reg;
    logic osc_fault_flag_next;
    logic pin_nmi_flag_reg;
    logic pin_nmi_flag_next;
    logic wdog_set;

    always_comb begin
        wdog_set = events_in.wdog_overflow || events_in.key_violation; // RQ4
        // Survives power_up_clear so software can see why it restarted
        wdog_event_flag_next = wdog_event_flag_reg;
        if (events_in.pin_reset) begin
            wdog_event_flag_next = `VAL_CLEAR; // RQ5
        end
        wdog_event_flag_next = flag_next(wdog_event_flag_next, wdog_set,
                                         wr_flags_1, wdata[`BIT_WDOG]);
        osc_fault_flag_next = flag_next(osc_fault_flag_reg, events_in.osc_fault,
                                        wr_flags_1, wdata[`BIT_OSC_FAULT]); // RQ6
        pin_nmi_flag_next = flag_next(pin_nmi_flag_reg, events_in.pin_nmi_event,
                                      wr_flags_1, wdata[`BIT_PIN_NMI]); // RQ7
        if (power_up_clear_in) begin
            osc_fault_flag_next = `VAL_OSC_FAULT_PUC; // RQ11
            pin_nmi_flag_next = `VAL_CLEAR; // RQ11
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_event_flag_reg <= `VAL_CLEAR; // RQ5
            osc_fault_flag_reg <= `VAL_OSC_FAULT_PUC;
            pin_nmi_flag_reg <= `VAL_CLEAR;
        end else begin
            wdog_event_flag_reg <= wdog_event_flag_next;
            osc_fault_flag_reg <= osc_fault_flag_next;
            pin_nmi_flag_reg <= pin_nmi_flag_next;
        end
    end

    // ==========================================================
    // Serial flags, index BIT_SERIAL_RX and BIT_SERIAL_TX
    logic [`SERIAL_CHANNELS-1:0] serial_flags_reg; // RQ1
    logic [`SERIAL_CHANNELS-1:0] serial_flags_next;
    logic [`SERIAL_CHANNELS-1:0] serial_set;

    always_comb begin
        serial_set = `VAL_SERIAL_PUC;
        serial_set[`BIT_SERIAL_RX] = events_in.serial_rx_event;
        serial_set[`BIT_SERIAL_TX] = events_in.serial_tx_event;
    end

    generate
        for (genvar i = 0; i < `SERIAL_CHANNELS; i++) begin : g_serial
            always_comb begin
                serial_flags_next[i] = flag_next(serial_flags_reg[i], serial_set[i],
                                                 wr_flags_2, wdata[i]); // RQ10
                if (power_up_clear_in) begin
                    serial_flags_next[i] = `VAL_CLEAR; // RQ11
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_flags_reg <= `VAL_SERIAL_PUC;
        end else begin
            serial_flags_reg <= serial_flags_next;
        end
    end

    // ==========================================================
    // Module enables
    logic serial_uart_rx_on_reg;
    logic serial_uart_rx_on_next;
    logic serial_uart_tx_on_reg;
    logic serial_uart_tx_on_next;
    logic serial_spi_on_reg;
    logic serial_spi_on_next;

    always_comb begin
        serial_uart_rx_on_next = serial_uart_rx_on_reg;
        serial_uart_tx_on_next = serial_uart_tx_on_reg;
        serial_spi_on_next = serial_spi_on_reg;
        if (wr_on_2) begin
            serial_uart_rx_on_next = wdata[`BIT_SERIAL_RX]; // RQ12
            serial_uart_tx_on_next = wdata[`BIT_SERIAL_TX]; // RQ12
            serial_spi_on_next = wdata[`BIT_SERIAL_SPI]; // RQ12
        end
        if (power_up_clear_in) begin
            serial_uart_rx_on_next = `VAL_CLEAR; // RQ11
            serial_uart_tx_on_next = `VAL_CLEAR;
            serial_spi_on_next = `VAL_CLEAR;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_uart_rx_on_reg <= `VAL_CLEAR;
            serial_uart_tx_on_reg <= `VAL_CLEAR;
            serial_spi_on_reg <= `VAL_CLEAR;
        end else begin
            serial_uart_rx_on_reg <= serial_uart_rx_on_next;
            serial_uart_tx_on_reg <= serial_uart_tx_on_next;
            serial_spi_on_reg <= serial_spi_on_next;
        end
    end

    // ==========================================================
    // Interrupt requests, registered
    sfr_bank_pkg::irq_s irq_reg;
    sfr_bank_pkg::irq_s irq_next;

    always_comb begin
        irq_next.wdog_irq = wdog_event_flag_reg && wdog_irq_en_reg
                            && events_in.wdog_interval_mode; // RQ3
        // No global enable term: these bypass the CPU's general mask
        irq_next.sys_nmi_irq = (osc_fault_flag_reg && osc_fault_irq_en_reg)
                               || (pin_nmi_flag_reg && pin_nmi_irq_en_reg)
                               || (events_in.flash_viol_flag
                                   && flash_viol_irq_en_reg); // RQ13
        irq_next.serial_rx_irq = serial_flags_reg[`BIT_SERIAL_RX]
                                 && serial_rx_irq_en_reg; // RQ9
        irq_next.serial_tx_irq = serial_flags_reg[`BIT_SERIAL_TX]
                                 && serial_tx_irq_en_reg; // RQ9
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // ==========================================================
    // Read path; absent bits and empty offsets read zero
    sfr_bank_pkg::byte_t rdata_reg;
    sfr_bank_pkg::byte_t rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    always_comb begin
        rdata_next = `SFR_BYTE_ZERO; // RQ14
        rvalid_next = sfr_hit && bus_req_in.rd;
        if (rvalid_next) begin
            case (ofs)
                `OFS_IRQ_EN_1: begin
                    rdata_next[`BIT_WDOG] = wdog_irq_en_reg;
                    rdata_next[`BIT_OSC_FAULT] = osc_fault_irq_en_reg;
                    rdata_next[`BIT_PIN_NMI] = pin_nmi_irq_en_reg;
                    rdata_next[`BIT_FLASH_VIOL] = flash_viol_irq_en_reg;
                end
                `OFS_IRQ_EN_2: begin
                    rdata_next[`BIT_SERIAL_RX] = serial_rx_irq_en_reg;
                    rdata_next[`BIT_SERIAL_TX] = serial_tx_irq_en_reg;
                end
                `OFS_IRQ_FLAGS_1: begin
                    rdata_next[`BIT_WDOG] = wdog_event_flag_reg;
                    rdata_next[`BIT_OSC_FAULT] = osc_fault_flag_reg;
                    rdata_next[`BIT_PIN_NMI] = pin_nmi_flag_reg;
                end
                `OFS_IRQ_FLAGS_2: begin
                    rdata_next[`SERIAL_CHANNELS-1:0] = serial_flags_reg; // RQ10
                end
                `OFS_MODULE_ON_2: begin
                    rdata_next[`BIT_SERIAL_RX] = serial_uart_rx_on_reg;
                    rdata_next[`BIT_SERIAL_TX] = serial_uart_tx_on_reg;
                    rdata_next[`BIT_SERIAL_SPI] = serial_spi_on_reg;
                end
                default: begin
                    rdata_next = `SFR_BYTE_ZERO; // RQ14
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= `SFR_BYTE_ZERO;
            rvalid_reg <= `VAL_CLEAR;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ==========================================================
    // Outputs, each straight from a flip-flop; no storage for others
    always_comb begin
        bus_rdata_out = rdata_reg;
        bus_rvalid_out = rvalid_reg;
        irq_out = irq_reg;
        module_on_out.serial_uart_rx_on = serial_uart_rx_on_reg;
        module_on_out.serial_uart_tx_on = serial_uart_tx_on_reg;
        module_on_out.serial_spi_on = serial_spi_on_reg;
    end

endmodule

`default_nettype wire

// [tb_top.sv]
// Testbench of the special function register bank.
// Assumes package, bank, checker and event model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_in;
    logic arst_n_in;
    logic power_up_clear_in;
    sfr_bank_pkg::bus_req_s bus_req_in;
    sfr_bank_pkg::event_s events_in;
    sfr_bank_pkg::byte_t bus_rdata_out;
    logic bus_rvalid_out;
    sfr_bank_pkg::irq_s irq_out;
    sfr_bank_pkg::module_on_s module_on_out;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam logic [8:0] ev_wov = 9'h100;
    localparam logic [8:0] ev_key = 9'h080;
    localparam logic [8:0] ev_prst = 9'h040;
    localparam logic [8:0] ev_mode = 9'h020;
    localparam logic [8:0] ev_osc = 9'h010;
    localparam logic [8:0] ev_nmi = 9'h008;
    localparam logic [8:0] ev_flv = 9'h004;
    localparam logic [8:0] ev_rx = 9'h002;
    localparam logic [8:0] ev_tx = 9'h001;
    logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
    logic [7:0] one_val [6] = '{8'h33, 8'h03, 8'h13, 8'h03, 8'h00, 8'h07};
    logic [7:0] puc_val [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    special_function_reg_bank dut (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .power_up_clear_in(power_up_clear_in),
        .bus_req_in(bus_req_in),
        .events_in(events_in),
        .bus_rdata_out(bus_rdata_out),
        .bus_rvalid_out(bus_rvalid_out),
        .irq_out(irq_out),
        .module_on_out(module_on_out)
    );
    event_source_model ev (
        .mclk_in(mclk_in),
        .events_out(events_in)
    );
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    // ==========
    // Bus tasks and comparison
    task automatic test_done();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus_req_in <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk_in);
        bus_req_in <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic vld);
        @(posedge mclk_in);
        bus_req_in <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk_in);
        bus_req_in <= '0;
        #1;
        chk({7'h00, bus_rvalid_out}, {7'h00, vld});
        chk(bus_rdata_out, exp);
    endtask
    task automatic irq_is(input logic [7:0] exp);
        repeat (3) @(posedge mclk_in);
        #1;
        chk({4'h0, irq_out}, exp);
    endtask
    // ==========
    // Test sequence
    initial begin
        arst_n_in = 1'b0;
        power_up_clear_in = 1'b0;
        bus_req_in = '0;
        repeat (8) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < 6; i++) rd(16'(i), rst_val[i], 1'b1);
        for (int i = 0; i < 6; i++) begin
            wr(16'(i), 8'hFF);
            rd(16'(i), one_val[i], 1'b1);
        end
        chk({5'h00, module_on_out}, 8'h07);
        irq_is(8'h07);
        rd(16'h0009, 8'h00, 1'b1);
        rd(16'h0010, 8'h00, 1'b0);
        wr(16'h0002, 8'h00);
        wr(16'h0003, 8'h00);
        irq_is(8'h00);
        ev.pulse(ev_rx);
        rd(16'h0003, 8'h01, 1'b1);
        ev.pulse(ev_tx);
        rd(16'h0003, 8'h03, 1'b1);
        irq_is(8'h03);
        fork
            wr(16'h0003, 8'h00);
            ev.pulse(ev_rx);
        join
        rd(16'h0003, 8'h01, 1'b1);
        ev.pulse(ev_wov);
        rd(16'h0002, 8'h01, 1'b1);
        irq_is(8'h02);
        ev.hold(ev_mode);
        irq_is(8'h0A);
        ev.pulse(ev_prst);
        rd(16'h0002, 8'h00, 1'b1);
        ev.pulse(ev_key);
        rd(16'h0002, 8'h01, 1'b1);
        ev.hold(9'h000);
        wr(16'h0000, 8'h23);
        ev.pulse(ev_nmi);
        rd(16'h0002, 8'h11, 1'b1);
        irq_is(8'h02);
        wr(16'h0000, 8'h33);
        irq_is(8'h06);
        wr(16'h0000, 8'h00);
        wr(16'h0002, 8'h00);
        ev.hold(ev_osc);
        rd(16'h0002, 8'h02, 1'b1);
        ev.hold(ev_flv);
        wr(16'h0000, 8'h20);
        irq_is(8'h06);
        wr(16'h0002, 8'h00);
        ev.pulse(ev_wov);
        @(posedge mclk_in);
        power_up_clear_in <= 1'b1;
        @(posedge mclk_in);
        power_up_clear_in <= 1'b0;
        for (int i = 0; i < 6; i++) rd(16'(i), puc_val[i], 1'b1);
        @(posedge mclk_in);
        arst_n_in <= 1'b0;
        @(posedge mclk_in);
        arst_n_in <= 1'b1;
        rd(16'h0002, 8'h02, 1'b1);
        test_done();
    end
endmodule
bind special_function_reg_bank sfr_bank_props props (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .power_up_clear_in(power_up_clear_in),
    .bus_req_in(bus_req_in),
    .events_in(events_in),
    .bus_rdata_out(bus_rdata_out),
    .bus_rvalid_out(bus_rvalid_out),
    .irq_out(irq_out),
    .module_on_out(module_on_out)
);
`default_nettype wire
